// *** vga_init_regs.svh ***
// Purpose: Offsets, field positions, reset values and codes of the VGA setup register bank.
// Assumes: Included by the register bank and its bench; definitions only.
// Notes: Offsets are byte addresses on the register bus.
`ifndef VGA_INIT_REGS_SVH
`define VGA_INIT_REGS_SVH

`define VIR_OFF_WORD0 8'h28
`define VIR_OFF_WORD1 8'h2c
`define VIR_OFF_CMD 8'h30
`define VIR_OFF_SRC 8'h34

`define VIR_W0_WRMASK 32'h007fff47
`define VIR_W0_RESET 32'h00000008
`define VIR_W1_WRMASK 32'h1fffffff
`define VIR_W1_RESET 32'h00000000

`define VIR_W0_DISABLE 0
`define VIR_W0_EXT_TIMING 1
`define VIR_W0_DAC_8BIT 2
`define VIR_W0_EXT_ENABLE 6
`define VIR_W0_WAKE_SEL 8
`define VIR_W0_LEGACY_OFF 9
`define VIR_W0_CFG_RB_OFF 10
`define VIR_W0_FAST_BLINK 11
`define VIR_W0_SHIFT_NOFETCH 12
`define VIR_W0_DAC_DECODE 13
`define VIR_W0_BASE_LO 14
`define VIR_W0_BASE_HI 21
`define VIR_W0_HB_REFRESH_OFF 22

`define VIR_W1_WR_AP_LO 0
`define VIR_W1_WR_AP_HI 9
`define VIR_W1_RD_AP_LO 10
`define VIR_W1_RD_AP_HI 19
`define VIR_W1_CHAIN4 20
`define VIR_W1_LOCK_HORIZ 21
`define VIR_W1_LOCK_VERT 22
`define VIR_W1_LOCK_H2 23
`define VIR_W1_LOCK_VSYNC 24
`define VIR_W1_LOCK_HSYNC 25
`define VIR_W1_LOCK_CLKSEL 26
`define VIR_W1_LOCK_RAMEN 27
`define VIR_W1_LOCK_CHARCLK 28

`define VIR_PORT_WAKE_CARD 16'h46e8
`define VIR_PORT_WAKE_BOARD 16'h03c3
`define VIR_PORT_WAKE_OFFSET 16'h00c3
`define VIR_PORT_SETUP 16'h0102

`define VIR_REFRESH_BURST 2'h3
`define VIR_STRAP_SETTLE 2'h3

`define VIR_RESP_OKAY 2'h0
`define VIR_RESP_SLVERR 2'h2

`endif

// *** vga_init_pkg.sv ***
// Purpose: Types shared by the VGA setup register bank and its users.
// Assumes: Constants live in vga_init_regs.svh.
// Notes: Nothing here holds a number of the hardware besides enum codes.
`default_nettype none
package vga_init_pkg;

    typedef enum logic [1:0] {
        TGT_CRTC = 2'b00,
        TGT_MISC = 2'b01,
        TGT_SEQ = 2'b10,
        TGT_OTHER = 2'b11
    } vga_target_e;

    typedef enum logic [2:0] {
        SEL_WORD0 = 3'b000,
        SEL_WORD1 = 3'b001,
        SEL_CMD = 3'b010,
        SEL_SRC = 3'b011,
        SEL_NONE = 3'b100
    } reg_sel_e;

    typedef struct packed {
        vga_target_e target;
        logic [7:0] index;
    } vga_wr_s;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0] strb;
    } blit_wr_s;

endpackage
`default_nettype wire

// *** vga_init_config_regs.sv ***
// Purpose: VGA setup register bank on AXI4-Lite, with lock filter, port gating and refresh burst.
// Assumes: VGA core request inputs come from logic on CLOCK; the strap is an outside pin.
// Notes: Writes to locked VGA bits come back as a keep mask with those bits cleared.
`timescale 1ns/10ps
`default_nettype none
`include "vga_init_regs.svh"

// Operation
// - Disable bit blocks every VGA core access, register and port alike.
// - CLUT width bit: zero six-bit, one eight-bit entries.
// - Extension bit turns on the extended CRTC registers.
// - Alternate config readback through CRTC index 1c enabled while bit is zero.
// - Wake port: zero uses 46e8, one uses 3c3 or base plus c3.
// - Legacy-off bit stops decode and blocks writes to 46e8 and 102; strap resets it.
// - Fast blink test bit speeds cursor and attribute blink.
// - Shift-out bit stops VGA memory fetch while pixels shift out.
// - VGA base in 64K units within the first 16M, reset zero.
// - Refresh bit zero: three refreshes after blank start, timeout deferred.
// - Refresh bit one: no blanking refreshes, timeout alone schedules them.
// - Write aperture in 32K steps.
// - Read aperture in 32K steps.
// - Chain-4 bit enables sequential addressing in the legacy window.
// - Horizontal lock rejects CRTC writes to indices 0 to 5 and 1a.
// - Vertical lock rejects writes to the vertical timing fields.
// - Six further bits lock H2, sync, clock, RAM enable and char clock.
// - Write at 30 acts as a write to the blit command register.
// - Write at 34 acts as a write to the blit source base register.
module vga_init_config_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic STRAP_MULTIMEDIA,
    input wire logic VGA_WR_VALID,
    input wire vga_init_pkg::vga_wr_s VGA_WR_REQ,
    output logic VGA_WR_STROBE,
    output logic [7:0] VGA_WR_KEEP,
    input wire logic IO_WR_VALID,
    input wire logic [15:0] IO_WR_ADDR,
    input wire logic [15:0] IO_BASE,
    output logic IO_WR_ACCEPT,
    output logic WAKE_HIT,
    input wire logic SCANOUT,
    input wire logic HBLANK_START,
    input wire logic SHIFT_ACTIVE,
    output logic REFRESH_REQ,
    output logic REFRESH_DEFER,
    output logic FETCH_ALLOW,
    output logic VGA_DISABLE,
    output logic EXT_TIMING,
    output logic DAC_8BIT,
    output logic EXT_ENABLE,
    output logic CFG_READBACK_EN,
    output logic WAKE_SEL_BOARD,
    output logic LEGACY_DECODE_OFF,
    output logic FAST_BLINK,
    output logic [7:0] VGA_BASE,
    output logic [9:0] VBE_WR_APERTURE,
    output logic [9:0] VBE_RD_APERTURE,
    output logic CHAIN4,
    output logic BLIT_CMD_WE,
    output logic BLIT_SRC_WE,
    output vga_init_pkg::blit_wr_s BLIT_WR
);

    logic [31:0] word0;
    logic [31:0] word1;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_exec;
    vga_init_pkg::reg_sel_e wr_sel;
    logic strap_s1;
    logic strap_s2;
    logic strap_s3;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic strap_load;
    logic [1:0] refresh_cnt;
    logic refresh_load;
    logic [7:0] lock_bits;
    logic io_blocked;
    logic wake_match;

    function automatic vga_init_pkg::reg_sel_e decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = addr[7:0];
        if ((addr >> 8) != '0) begin
            return vga_init_pkg::SEL_NONE;
        end
        case (a)
            `VIR_OFF_WORD0: return vga_init_pkg::SEL_WORD0;
            `VIR_OFF_WORD1: return vga_init_pkg::SEL_WORD1;
            `VIR_OFF_CMD: return vga_init_pkg::SEL_CMD;
            `VIR_OFF_SRC: return vga_init_pkg::SEL_SRC;
            default: return vga_init_pkg::SEL_NONE;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old & ~m) | (data & m);
    endfunction

    // Bits of the addressed VGA register that the current locks protect.
    function automatic logic [7:0] lock_of(input vga_init_pkg::vga_wr_s req,
                                           input logic [31:0] w1);
        logic [7:0] l;
        logic hz;
        logic vt;
        l = 8'h00;
        hz = w1[`VIR_W1_LOCK_HORIZ];
        vt = w1[`VIR_W1_LOCK_VERT];
        case (req.target)
            vga_init_pkg::TGT_CRTC: begin
                case (req.index)
                    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h1a: l = {8{hz}};
                    8'h06, 8'h09, 8'h10, 8'h15, 8'h16, 8'h1b: l = {8{vt}};
                    8'h07: l = {8{vt}} & 8'had;
                    8'h11: l = {8{vt}} & 8'h0f;
                    8'h17: l = {5'h00, w1[`VIR_W1_LOCK_H2], 2'h0};
                    default: l = 8'h00;
                endcase
            end
            vga_init_pkg::TGT_MISC: begin
                l = {w1[`VIR_W1_LOCK_VSYNC], w1[`VIR_W1_LOCK_HSYNC], 2'h0,
                     {2{w1[`VIR_W1_LOCK_CLKSEL]}}, w1[`VIR_W1_LOCK_RAMEN], 1'b0};
            end
            vga_init_pkg::TGT_SEQ: begin
                l = {7'h00, (req.index == 8'h01) & w1[`VIR_W1_LOCK_CHARCLK]};
            end
            default: l = 8'h00;
        endcase
        return l;
    endfunction

    assign wr_exec = !AWREADY && !WREADY && !BVALID;
    assign wr_sel = decode(aw_addr);

    // Write address and data are taken in either order and held until the write runs.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                AWREADY <= 1'b0;
                aw_addr <= AWADDR;
            end else if (wr_exec) begin
                AWREADY <= 1'b1;
            end
            if (WVALID && WREADY) begin
                WREADY <= 1'b0;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end else if (wr_exec) begin
                WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            BVALID <= 1'b0;
            BRESP <= `VIR_RESP_OKAY;
        end else if (wr_exec) begin
            BVALID <= 1'b1;
            BRESP <= (wr_sel == vga_init_pkg::SEL_NONE) ? `VIR_RESP_SLVERR : `VIR_RESP_OKAY;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // The strap pin is synchronised and caught once it has settled after reset.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            strap_s3 <= 1'b0;
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
        end else begin
            strap_s1 <= STRAP_MULTIMEDIA;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            if (strap_cnt != `VIR_STRAP_SETTLE) begin
                strap_cnt <= strap_cnt + 2'h1;
            end
            if (strap_load) begin
                strap_done <= 1'b1;
            end
        end
    end

    assign strap_load = !strap_done && (strap_cnt == `VIR_STRAP_SETTLE) && (strap_s2 == strap_s3);

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            word0 <= `VIR_W0_RESET;
        end else if (wr_exec && wr_sel == vga_init_pkg::SEL_WORD0) begin
            word0 <= merge(word0, w_data, w_strb, `VIR_W0_WRMASK);
        end else if (strap_load) begin
            word0[`VIR_W0_LEGACY_OFF] <= strap_s3;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            word1 <= `VIR_W1_RESET;
        end else if (wr_exec && wr_sel == vga_init_pkg::SEL_WORD1) begin
            word1 <= merge(word1, w_data, w_strb, `VIR_W1_WRMASK);
        end
    end

    // Writes at the alias offsets are passed to the blit unit as one-cycle strobes.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            BLIT_CMD_WE <= 1'b0;
            BLIT_SRC_WE <= 1'b0;
            BLIT_WR <= '0;
        end else begin
            BLIT_CMD_WE <= wr_exec && wr_sel == vga_init_pkg::SEL_CMD;
            BLIT_SRC_WE <= wr_exec && wr_sel == vga_init_pkg::SEL_SRC;
            if (wr_exec) begin
                BLIT_WR <= '{data: w_data, strb: w_strb};
            end
        end
    end

    // Reads answer one cycle after the address is taken; alias offsets read as zero.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= `VIR_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RRESP <= `VIR_RESP_OKAY;
            case (decode(ARADDR))
                vga_init_pkg::SEL_WORD0: RDATA <= word0;
                vga_init_pkg::SEL_WORD1: RDATA <= word1;
                vga_init_pkg::SEL_CMD, vga_init_pkg::SEL_SRC: RDATA <= 32'h00000000;
                default: begin
                    RDATA <= 32'h00000000;
                    RRESP <= `VIR_RESP_SLVERR;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    assign lock_bits = lock_of(VGA_WR_REQ, word1);

    // Core register writes: whole write dropped when disabled, locked bits masked off.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            VGA_WR_STROBE <= 1'b0;
            VGA_WR_KEEP <= 8'h00;
        end else begin
            VGA_WR_STROBE <= VGA_WR_VALID && !word0[`VIR_W0_DISABLE];
            VGA_WR_KEEP <= ~lock_bits;
        end
    end

    assign io_blocked = word0[`VIR_W0_DISABLE] ||
                        (word0[`VIR_W0_LEGACY_OFF] &&
                         (IO_WR_ADDR == `VIR_PORT_WAKE_CARD || IO_WR_ADDR == `VIR_PORT_SETUP));
    assign wake_match = word0[`VIR_W0_WAKE_SEL] ?
                        (IO_WR_ADDR == `VIR_PORT_WAKE_BOARD ||
                         IO_WR_ADDR == IO_BASE + `VIR_PORT_WAKE_OFFSET) :
                        (IO_WR_ADDR == `VIR_PORT_WAKE_CARD);

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            IO_WR_ACCEPT <= 1'b0;
            WAKE_HIT <= 1'b0;
        end else begin
            IO_WR_ACCEPT <= IO_WR_VALID && !io_blocked;
            WAKE_HIT <= IO_WR_VALID && !io_blocked && wake_match;
        end
    end

    assign refresh_load = SCANOUT && HBLANK_START && !word0[`VIR_W0_HB_REFRESH_OFF];

    // Three refresh requests follow each blanking start during scan-out unless blanking refresh is off.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            refresh_cnt <= 2'h0;
            REFRESH_REQ <= 1'b0;
            REFRESH_DEFER <= 1'b0;
        end else begin
            if (refresh_load) begin
                refresh_cnt <= `VIR_REFRESH_BURST - 2'h1;
                REFRESH_REQ <= 1'b1;
            end else if (refresh_cnt != 2'h0 && !word0[`VIR_W0_HB_REFRESH_OFF]) begin
                refresh_cnt <= refresh_cnt - 2'h1;
                REFRESH_REQ <= 1'b1;
            end else begin
                refresh_cnt <= 2'h0;
                REFRESH_REQ <= 1'b0;
            end
            REFRESH_DEFER <= SCANOUT && !word0[`VIR_W0_HB_REFRESH_OFF];
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            FETCH_ALLOW <= 1'b1;
        end else begin
            FETCH_ALLOW <= !word0[`VIR_W0_DISABLE] &&
                           !(word0[`VIR_W0_SHIFT_NOFETCH] && SHIFT_ACTIVE);
        end
    end

    assign VGA_DISABLE = word0[`VIR_W0_DISABLE];
    assign EXT_TIMING = word0[`VIR_W0_EXT_TIMING];
    assign DAC_8BIT = word0[`VIR_W0_DAC_8BIT];
    assign EXT_ENABLE = word0[`VIR_W0_EXT_ENABLE];
    assign CFG_READBACK_EN = !word0[`VIR_W0_CFG_RB_OFF];
    assign WAKE_SEL_BOARD = word0[`VIR_W0_WAKE_SEL];
    assign LEGACY_DECODE_OFF = word0[`VIR_W0_LEGACY_OFF];
    assign FAST_BLINK = word0[`VIR_W0_FAST_BLINK];
    assign VGA_BASE = word0[`VIR_W0_BASE_HI:`VIR_W0_BASE_LO];
    assign VBE_WR_APERTURE = word1[`VIR_W1_WR_AP_HI:`VIR_W1_WR_AP_LO];
    assign VBE_RD_APERTURE = word1[`VIR_W1_RD_AP_HI:`VIR_W1_RD_AP_LO];
    assign CHAIN4 = word1[`VIR_W1_CHAIN4];

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    a_disable_blocks_core: assert property (
        VGA_WR_VALID && word0[`VIR_W0_DISABLE] |=> !VGA_WR_STROBE && !FETCH_ALLOW)
        else $error("core write passed while VGA disabled");

    a_legacy_port_block: assert property (
        IO_WR_VALID && word0[`VIR_W0_LEGACY_OFF] && IO_WR_ADDR == `VIR_PORT_SETUP
        |=> !IO_WR_ACCEPT)
        else $error("port write accepted while legacy decode off");

    a_wake_board_port: assert property (
        IO_WR_VALID && !word0[`VIR_W0_DISABLE] && word0[`VIR_W0_WAKE_SEL] &&
        IO_WR_ADDR == `VIR_PORT_WAKE_BOARD |=> WAKE_HIT)
        else $error("board wake port missed");

    a_refresh_three_burst: assert property (
        refresh_load ##1 (!word0[`VIR_W0_HB_REFRESH_OFF] && !refresh_load) [*3]
        |-> REFRESH_REQ && $past(REFRESH_REQ) && $past(REFRESH_REQ, 2) ##1 !REFRESH_REQ)
        else $error("refresh burst wrong length");

    a_refresh_off_quiet: assert property (
        word0[`VIR_W0_HB_REFRESH_OFF] |=> !REFRESH_REQ)
        else $error("refresh raised while blanking refresh off");

    a_horiz_lock_mask: assert property (
        VGA_WR_VALID && VGA_WR_REQ.target == vga_init_pkg::TGT_CRTC &&
        VGA_WR_REQ.index == 8'h1a && word1[`VIR_W1_LOCK_HORIZ] |=> VGA_WR_KEEP == 8'h00)
        else $error("horizontal lock not applied");

    a_vert_lock_mask: assert property (
        VGA_WR_REQ.target == vga_init_pkg::TGT_CRTC && VGA_WR_REQ.index == 8'h07 &&
        word1[`VIR_W1_LOCK_VERT] |=> VGA_WR_KEEP == 8'h52)
        else $error("vertical lock mask wrong at index 7");

    a_misc_lock_mask: assert property (
        VGA_WR_REQ.target == vga_init_pkg::TGT_MISC && word1[`VIR_W1_LOCK_CLKSEL] &&
        !word1[`VIR_W1_LOCK_VSYNC] |=> VGA_WR_KEEP[3:2] == 2'h0 && VGA_WR_KEEP[7])
        else $error("misc output lock mask wrong");

    a_alias_command: assert property (
        wr_exec && wr_sel == vga_init_pkg::SEL_CMD
        |=> BLIT_CMD_WE && !BLIT_SRC_WE && BLIT_WR.data == $past(w_data) ##1 !BLIT_CMD_WE)
        else $error("command alias strobe wrong");

    a_alias_source: assert property (
        wr_exec && wr_sel == vga_init_pkg::SEL_SRC |=> BLIT_SRC_WE && BVALID)
        else $error("source alias strobe wrong");

    c_refresh_burst: cover property (refresh_load ##1 REFRESH_REQ [*3]);
    c_locked_write: cover property (VGA_WR_STROBE && VGA_WR_KEEP != 8'hff);
    c_alias_write: cover property (BLIT_CMD_WE ##[1:20] BLIT_SRC_WE);

endmodule
`default_nettype wire

// *** vga_init_config_regs_bench.sv ***
// Purpose: Self-checking bench for the VGA setup register bank over AXI4-Lite.
// Assumes: Bench drives every port itself; tasks speak AXI4-Lite and the core request ports.
// Notes: Outputs are read at the edge after the one that registers them.
`timescale 1ns/10ps
`default_nettype none
`include "vga_init_regs.svh"
module vga_init_config_regs_bench;
    logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready, strap, vga_valid, io_valid;
    logic scanout, hblank, shift, awready, wready, bvalid, arready, rvalid, vga_strobe;
    logic io_accept, wake_hit, refresh_req, refresh_defer, fetch_allow, vga_disable, ext_timing;
    logic dac_8bit, ext_enable, cfg_rb_en, wake_board, legacy_off, fast_blink, chain4;
    logic cmd_we, src_we;
    logic [7:0] awaddr, araddr, vga_keep, vga_base;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] io_addr, io_base;
    logic [9:0] wr_ap, rd_ap;
    vga_init_pkg::vga_wr_s vga_req;
    vga_init_pkg::blit_wr_s blit_wr;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int cmd_n = 0;
    int src_n = 0;

    vga_init_config_regs vga_init_config_regs_i (
        .CLOCK(clock), .RST_N(rst_n), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready), .STRAP_MULTIMEDIA(strap), .VGA_WR_VALID(vga_valid),
        .VGA_WR_REQ(vga_req), .VGA_WR_STROBE(vga_strobe), .VGA_WR_KEEP(vga_keep),
        .IO_WR_VALID(io_valid), .IO_WR_ADDR(io_addr), .IO_BASE(io_base),
        .IO_WR_ACCEPT(io_accept), .WAKE_HIT(wake_hit), .SCANOUT(scanout),
        .HBLANK_START(hblank), .SHIFT_ACTIVE(shift), .REFRESH_REQ(refresh_req),
        .REFRESH_DEFER(refresh_defer), .FETCH_ALLOW(fetch_allow), .VGA_DISABLE(vga_disable),
        .EXT_TIMING(ext_timing), .DAC_8BIT(dac_8bit), .EXT_ENABLE(ext_enable),
        .CFG_READBACK_EN(cfg_rb_en), .WAKE_SEL_BOARD(wake_board),
        .LEGACY_DECODE_OFF(legacy_off), .FAST_BLINK(fast_blink), .VGA_BASE(vga_base),
        .VBE_WR_APERTURE(wr_ap), .VBE_RD_APERTURE(rd_ap), .CHAIN4(chain4),
        .BLIT_CMD_WE(cmd_we), .BLIT_SRC_WE(src_we), .BLIT_WR(blit_wr)
    );

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cmd_we === 1'b1)
            cmd_n++;
        if (src_we === 1'b1)
            src_n++;
        if (cycles == 4000) begin
            num_errors++;
            $display("MISMATCH %0t run did not finish", $time);
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock);
            if (awready === 1'b1 && !aw_ok) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_ok) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er), "write response");
        @(posedge clock);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, exp, "read data");
        chk(32'(rresp), 32'(er), "read response");
        @(posedge clock);
    endtask

    task automatic vga_case(input logic [1:0] t, input logic [7:0] i, input logic s,
                            input logic [7:0] k);
        vga_req <= {t, i};
        vga_valid <= 1'b1;
        @(posedge clock);
        vga_valid <= 1'b0;
        @(posedge clock);
        chk(32'({vga_strobe, vga_keep}), 32'({s, k}), "core write filter");
    endtask

    task automatic lock_case(input int b, input logic [1:0] t, input logic [7:0] i,
                             input logic [7:0] k);
        axi_wr(`VIR_OFF_WORD1, 32'h1 << b, 4'hf, 2'h0);
        vga_case(t, i, 1'b1, k);
    endtask

    task automatic io_case(input logic [15:0] a, input logic acc, input logic wk);
        io_addr <= a;
        io_valid <= 1'b1;
        @(posedge clock);
        io_valid <= 1'b0;
        @(posedge clock);
        chk(32'({io_accept, wake_hit}), 32'({acc, wk}), "port write");
    endtask

    task automatic refresh_case(input logic off);
        hblank <= 1'b1;
        @(posedge clock);
        hblank <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            chk(32'(refresh_req), 32'(!off && k < 3), "refresh burst");
        end
        chk(32'(refresh_defer), 32'(!off), "refresh defer");
    endtask

    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, strap, vga_valid, io_valid} = '0;
        {hblank, shift, awaddr, araddr, wdata, wstrb, io_addr, io_base, vga_req} = '0;
        scanout = 1'b1;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk(32'({fetch_allow, cfg_rb_en, vga_disable, refresh_req}), 32'hc,
            "reset outputs");
        axi_rd(`VIR_OFF_WORD0, 32'h00000008, 2'h0);
        axi_rd(`VIR_OFF_WORD1, 32'h0, 2'h0);
        axi_rd(`VIR_OFF_CMD, 32'h0, 2'h0);
        axi_rd(8'h40, 32'h0, 2'h2);
        axi_wr(8'h40, 32'hffffffff, 4'hf, 2'h2);
        axi_rd(`VIR_OFF_WORD0, 32'h00000008, 2'h0);
        axi_wr(`VIR_OFF_WORD0, 32'hffffdfff, 4'hf, 2'h0);
        axi_rd(`VIR_OFF_WORD0, 32'h007fdf4f, 2'h0);
        chk(32'({vga_disable, ext_timing, dac_8bit, ext_enable, wake_board, legacy_off,
                 fast_blink, cfg_rb_en, vga_base}), 32'hfeff,
            "word0 fields");
        chk(32'(fetch_allow), 32'h0, "fetch while disabled");
        vga_case(2'h0, 8'h06, 1'b0, 8'hff);
        io_case(16'h03c3, 1'b0, 1'b0);
        refresh_case(1'b1);
        axi_wr(`VIR_OFF_WORD0, 32'h0, 4'h1, 2'h0);
        axi_rd(`VIR_OFF_WORD0, 32'h007fdf08, 2'h0);
        io_base <= 16'h0200;
        io_case(16'h46e8, 1'b0, 1'b0);
        io_case(16'h0102, 1'b0, 1'b0);
        io_case(16'h03c3, 1'b1, 1'b1);
        io_case(16'h02c3, 1'b1, 1'b1);
        io_case(16'h03c0, 1'b1, 1'b0);
        axi_wr(`VIR_OFF_WORD0, 32'h00169004, 4'hf, 2'h0);
        axi_rd(`VIR_OFF_WORD0, 32'h0016900c, 2'h0);
        chk(32'({vga_disable, ext_timing, dac_8bit, ext_enable, wake_board, legacy_off,
                 fast_blink, cfg_rb_en, vga_base}), 32'h215a,
            "word0 fields");
        io_case(16'h46e8, 1'b1, 1'b1);
        io_case(16'h03c3, 1'b1, 1'b0);
        refresh_case(1'b0);
        shift <= 1'b1;
        repeat (2) @(posedge clock);
        chk(32'(fetch_allow), 32'h0, "fetch during shift out");
        shift <= 1'b0;
        repeat (2) @(posedge clock);
        chk(32'(fetch_allow), 32'h1, "fetch after shift out");
        axi_wr(`VIR_OFF_WORD1, 32'h00155aa5, 4'hf, 2'h0);
        axi_rd(`VIR_OFF_WORD1, 32'h00155aa5, 2'h0);
        chk(32'({chain4, rd_ap, wr_ap}), 32'h00155aa5, "apertures");
        axi_wr(`VIR_OFF_WORD1, 32'hffffffff, 4'hf, 2'h0);
        axi_rd(`VIR_OFF_WORD1, 32'h1fffffff, 2'h0);
        lock_case(21, 2'h0, 8'h00, 8'h00);
        lock_case(21, 2'h0, 8'h1a, 8'h00);
        lock_case(21, 2'h0, 8'h06, 8'hff);
        lock_case(22, 2'h0, 8'h07, 8'h52);
        lock_case(22, 2'h0, 8'h11, 8'hf0);
        lock_case(22, 2'h0, 8'h1b, 8'h00);
        lock_case(23, 2'h0, 8'h17, 8'hfb);
        lock_case(24, 2'h1, 8'h00, 8'h7f);
        lock_case(25, 2'h1, 8'h00, 8'hbf);
        lock_case(26, 2'h1, 8'h00, 8'hf3);
        lock_case(27, 2'h1, 8'h00, 8'hfd);
        lock_case(28, 2'h2, 8'h01, 8'hfe);
        lock_case(28, 2'h2, 8'h00, 8'hff);
        axi_wr(`VIR_OFF_CMD, 32'hdeadbeef, 4'hf, 2'h0);
        chk(blit_wr.data, 32'hdeadbeef, "command alias data");
        chk(32'({cmd_n[3:0], src_n[3:0], blit_wr.strb}), 32'h10f,
            "command alias pulse");
        axi_wr(`VIR_OFF_SRC, 32'h12345678, 4'h3, 2'h0);
        chk(blit_wr.data, 32'h12345678, "source alias data");
        chk(32'({cmd_n[3:0], src_n[3:0], blit_wr.strb}), 32'h113,
            "source alias pulse");
        axi_rd(`VIR_OFF_SRC, 32'h0, 2'h0);
        rst_n <= 1'b0;
        strap <= 1'b1;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        axi_rd(`VIR_OFF_WORD0, 32'h00000208, 2'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
